/* File: src/tzs_pkg.sv */
package tzs_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] REG_LOCAL_TEMP     = 8'h00;
	localparam logic [7:0] REG_CONTROL        = 8'h01;
	localparam logic [7:0] REG_LOCAL_HYST     = 8'h02;
	localparam logic [7:0] REG_LOCAL_SET      = 8'h03;
	localparam logic [7:0] REG_REMOTE_TEMP    = 8'h10;
	localparam logic [7:0] REG_REMOTE_HYST    = 8'h12;
	localparam logic [7:0] REG_REMOTE_SET     = 8'h13;
	localparam logic [7:0] REG_RELEASE        = 8'h22;
	localparam logic [7:0] REG_TRIP           = 8'h23;

	// ----------------------------------------
	// control_settings fields
	// ----------------------------------------
	localparam int         CFG_HALT_BIT       = 0;
	localparam int         CFG_MODE_BIT       = 1;
	localparam int         CFG_MASK_BIT       = 2;
	localparam int         CFG_FQ_LSB         = 3;
	localparam int         CFG_CTL_W          = 5;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [4:0] RST_CONTROL        = 5'h00;
	localparam logic [7:0] RST_LOCAL_SET      = 8'h51;
	localparam logic [7:0] RST_LOCAL_HYST     = 8'h4C;
	localparam logic [7:0] RST_REMOTE_SET     = 8'h61;
	localparam logic [7:0] RST_REMOTE_HYST    = 8'h5C;
	localparam logic [7:0] RST_TRIP           = 8'h61;
	localparam logic [7:0] RST_RELEASE        = 8'h5C;
	localparam logic [7:0] FULL_SCALE         = 8'h7F;

	// ----------------------------------------
	// addressing, filters, timing
	// ----------------------------------------
	localparam logic [5:0] ADDR_UPPER         = 6'h24;
	localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
	localparam logic [2:0] FQ_DEPTH [4]       = '{3'h1, 3'h2, 3'h4, 3'h6};
	localparam logic [15:0] CONV_LOCAL_CYC    = 16'h0040;
	localparam logic       ZONE_LOCAL         = 1'b0;
	localparam logic       ZONE_REMOTE        = 1'b1;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
		ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
	} tzs_bus_state_t;

	typedef struct packed {
		logic       zone;
		logic [7:0] value;
	} tzs_result_t;

	typedef struct packed {
		logic o;
		logic oe;
	} tzs_od_t;

endpackage

/* File: src/tzs_core.sv */
`timescale 1ns/10ps
`default_nettype none
module tzs_core #(
	parameter logic [5:0]  ADDR_HI        = tzs_pkg::ADDR_UPPER,
	parameter logic [15:0] LOCAL_CONV_CYC = tzs_pkg::CONV_LOCAL_CYC
) (
	// system
	input  wire logic              clk,
	input  wire logic              sys_rst,
	// conversion clock domain
	input  wire logic              adc_clk,
	input  wire logic [7:0]        adc_sample,
	input  wire logic              remote_diode_sense_bad,
	// serial bus
	input  wire logic              scl_i,
	input  wire logic              sda_i,
	output var  logic              sda_o,
	output var  logic              sda_oe,
	input  wire logic              addr_select_pin,
	// open-drain event pins
	output var  tzs_pkg::tzs_od_t  alert_pin,
	output var  tzs_pkg::tzs_od_t  overheat_out
);
	import tzs_pkg::*;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0]           scl_sync;
	logic [1:0]           sda_sync;
	logic [1:0]           a0_sync;
	logic                 scl_q;
	logic                 sda_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
			a0_sync  <= 2'h0;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
		end else begin
			scl_sync <= {scl_sync[0], scl_i};
			sda_sync <= {sda_sync[0], sda_i};
			a0_sync  <= {a0_sync[0], addr_select_pin};
			scl_q    <= scl_sync[1];
			sda_q    <= sda_sync[1];
		end
	end

	wire scl_h      = scl_sync[1];
	wire sda_h      = sda_sync[1];
	wire start_cond = scl_h & scl_q & sda_q & ~sda_h;
	wire stop_cond  = scl_h & scl_q & ~sda_q & sda_h;
	wire scl_rise   = scl_h & ~scl_q;
	wire scl_fall   = ~scl_h & scl_q;

	// ----------------------------------------
	// serial slave
	// ----------------------------------------
	tzs_bus_state_t       state;
	logic [3:0]           bit_cnt;
	logic [7:0]           shift;
	logic [7:0]           tx;
	logic                 rw;
	logic                 nack;
	logic                 selected;
	logic [7:0]           ptr;
	logic [7:0]           rd_data;

	wire [6:0] own_addr  = {ADDR_HI, a0_sync[1]};
	wire       byte_full = (bit_cnt == BITS_PER_BYTE);
	wire       addr_hit  = (shift[7:1] == own_addr);
	wire       byte_end  = scl_fall & byte_full;
	wire       cmd_wr    = byte_end & (state == ST_CMD);
	wire       data_wr   = byte_end & (state == ST_WDATA);
	// any read start loads from pointer
	wire       rd_load   = scl_fall & (((state == ST_ADDR_ACK) & rw) | ((state == ST_RACK) & ~nack));

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			shift    <= 8'h00;
			tx       <= 8'h00;
			rw       <= 1'b0;
			nack     <= 1'b0;
			selected <= 1'b0;
			sda_oe   <= 1'b0;
		end else if (start_cond) begin
			state    <= ST_ADDR;
			bit_cnt  <= 4'h0;
			selected <= 1'b0;
			sda_oe   <= 1'b0;
		end else if (stop_cond) begin
			state    <= ST_IDLE;
			selected <= 1'b0;
			sda_oe   <= 1'b0;
		end else begin
			if (scl_rise) begin
				shift   <= {shift[6:0], sda_h};
				bit_cnt <= bit_cnt + 4'h1;
				if (state == ST_RACK) begin
					nack <= sda_h;
				end
			end
			if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						if (byte_full && addr_hit) begin
							state    <= ST_ADDR_ACK;
							rw       <= shift[0];
							selected <= 1'b1;
							sda_oe   <= 1'b1;
						end else if (byte_full) begin
							state <= ST_IDLE;
						end
					end
					ST_CMD: begin
						if (byte_full) begin
							state  <= ST_CMD_ACK;
							sda_oe <= 1'b1;
						end
					end
					ST_WDATA: begin
						if (byte_full) begin
							state  <= ST_WDATA_ACK;
							sda_oe <= 1'b1;
						end
					end
					ST_ADDR_ACK: begin
						bit_cnt <= 4'h0;
						if (rw) begin
							state  <= ST_RDATA;
							tx     <= rd_data;
							sda_oe <= ~rd_data[7];
						end else begin
							state  <= ST_CMD;
							sda_oe <= 1'b0;
						end
					end
					ST_CMD_ACK, ST_WDATA_ACK: begin
						bit_cnt <= 4'h0;
						state   <= ST_WDATA;
						sda_oe  <= 1'b0;
					end
					ST_RDATA: begin
						if (byte_full) begin
							state   <= ST_RACK;
							bit_cnt <= 4'h0;
							sda_oe  <= 1'b0;
						end else begin
							tx     <= {tx[6:0], 1'b0};
							sda_oe <= ~tx[6];
						end
					end
					ST_RACK: begin
						bit_cnt <= 4'h0;
						if (nack) begin
							state <= ST_IDLE;
						end else begin
							state  <= ST_RDATA;
							tx     <= rd_data;
							sda_oe <= ~rd_data[7];
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		sda_o <= 1'b0;
	end

	// pointer only replaced by command byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ptr <= REG_LOCAL_TEMP;
		end else if (cmd_wr) begin
			ptr <= shift;
		end
	end

	// ----------------------------------------
	// register file
	// ----------------------------------------
	logic [CFG_CTL_W-1:0] cfg_ctl;
	logic [7:0]           local_temp_result;
	logic [7:0]           remote_temp_result;
	logic [7:0]           set0;
	logic [7:0]           hyst0;
	logic [7:0]           set1;
	logic [7:0]           hyst1;
	logic [7:0]           trip;
	logic [7:0]           release_lim;
	logic [1:0]           stat;
	logic                 overheat_out_state;

	wire       cfg_halt  = cfg_ctl[CFG_HALT_BIT];
	wire       mode_int  = cfg_ctl[CFG_MODE_BIT];
	wire       cfg_mask  = cfg_ctl[CFG_MASK_BIT];
	wire [2:0] fq_depth  = FQ_DEPTH[cfg_ctl[CFG_FQ_LSB +: 2]];
	wire [7:0] cfg_read  = {overheat_out_state, stat, cfg_ctl};

	assign rd_data = (ptr == REG_LOCAL_TEMP)  ? local_temp_result :
	                 (ptr == REG_CONTROL)     ? cfg_read :
	                 (ptr == REG_LOCAL_HYST)  ? hyst0 :
	                 (ptr == REG_LOCAL_SET)   ? set0 :
	                 (ptr == REG_REMOTE_TEMP) ? remote_temp_result :
	                 (ptr == REG_REMOTE_HYST) ? hyst1 :
	                 (ptr == REG_REMOTE_SET)  ? set1 :
	                 (ptr == REG_RELEASE)     ? release_lim :
	                 (ptr == REG_TRIP)        ? trip : 8'h00;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_ctl     <= RST_CONTROL;
			set0        <= RST_LOCAL_SET;
			hyst0       <= RST_LOCAL_HYST;
			set1        <= RST_REMOTE_SET;
			hyst1       <= RST_REMOTE_HYST;
			trip        <= RST_TRIP;
			release_lim <= RST_RELEASE;
		end else if (data_wr) begin
			if (ptr == REG_CONTROL)     cfg_ctl     <= shift[CFG_CTL_W-1:0];
			if (ptr == REG_LOCAL_SET)   set0        <= shift;
			if (ptr == REG_LOCAL_HYST)  hyst0       <= shift;
			if (ptr == REG_REMOTE_SET)  set1        <= shift;
			if (ptr == REG_REMOTE_HYST) hyst1       <= shift;
			if (ptr == REG_TRIP)        trip        <= shift;
			if (ptr == REG_RELEASE)     release_lim <= shift;
		end
	end

	// ----------------------------------------
	// conversion sequencer (adc_clk)
	// ----------------------------------------
	localparam logic [15:0] REMOTE_CONV_CYC = 16'(2 * LOCAL_CONV_CYC);

	logic [1:0]           arst_sync;
	logic [1:0]           busy_sync;
	logic [1:0]           halt_sync;
	logic [1:0]           fault_sync;
	logic                 adc_zone;
	logic [15:0]          conv_cnt;
	tzs_result_t          res;
	logic                 res_tgl;

	wire        adc_rst   = arst_sync[1];
	wire [15:0] conv_len  = (adc_zone == ZONE_REMOTE) ? REMOTE_CONV_CYC : LOCAL_CONV_CYC;
	wire        conv_done = (conv_cnt == conv_len - 16'h0001);

	always_ff @(posedge adc_clk) begin
		arst_sync  <= {arst_sync[0], sys_rst};
		busy_sync  <= {busy_sync[0], selected};
		halt_sync  <= {halt_sync[0], cfg_halt};
		fault_sync <= {fault_sync[0], remote_diode_sense_bad};
	end

	always_ff @(posedge adc_clk) begin
		if (adc_rst) begin
			adc_zone <= ZONE_REMOTE;
			conv_cnt <= 16'h0000;
			res      <= '0;
			res_tgl  <= 1'b0;
		// access aborts, next cycle starts remote
		end else if (busy_sync[1] || halt_sync[1]) begin
			adc_zone <= ZONE_REMOTE;
			conv_cnt <= 16'h0000;
		end else if (conv_done) begin
			conv_cnt  <= 16'h0000;
			adc_zone  <= ~adc_zone;
			res.zone  <= adc_zone;
			res.value <= (adc_zone == ZONE_REMOTE && fault_sync[1]) ? FULL_SCALE : adc_sample;
			res_tgl   <= ~res_tgl;
		end else begin
			conv_cnt <= conv_cnt + 16'h0001;
		end
	end

	// ----------------------------------------
	// result crossing and evaluation
	// ----------------------------------------
	// result word is held for a whole conversion, far longer than the toggle takes to cross
	logic [2:0]           tgl_sync;
	logic                 upd_q;
	logic                 upd_zone;
	logic                 halt_q;
	logic [7:0]           fn_val [3];
	logic [7:0]           fn_hi  [3];
	logic [7:0]           fn_lo  [3];
	logic [2:0]           hi_valid;
	logic [2:0]           lo_valid;
	logic [1:0]           set_int;

	wire res_evt   = tgl_sync[1] ^ tgl_sync[2];
	wire halt_rise = cfg_halt & ~halt_q;
	wire clear_int = rd_load | halt_rise;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tgl_sync <= 3'h0;
			local_temp_result    <= 8'h00;
			remote_temp_result    <= 8'h00;
			upd_q    <= 1'b0;
			upd_zone <= ZONE_LOCAL;
			halt_q   <= 1'b0;
		end else begin
			tgl_sync <= {tgl_sync[1:0], res_tgl};
			upd_q    <= res_evt;
			upd_zone <= res.zone;
			halt_q   <= cfg_halt;
			if (res_evt && res.zone == ZONE_LOCAL) local_temp_result <= res.value;
			if (res_evt && res.zone == ZONE_REMOTE) remote_temp_result <= res.value;
		end
	end

	assign fn_val = '{local_temp_result, remote_temp_result, remote_temp_result};
	assign fn_hi  = '{set0, set1, trip};
	assign fn_lo  = '{hyst0, hyst1, release_lim};

	genvar f;
	generate
		for (f = 0; f < 3; f++) begin : g_filt
			logic [2:0] hi_cnt;
			logic [2:0] lo_cnt;
			wire        upd        = upd_q & (upd_zone == ((f == 0) ? ZONE_LOCAL : ZONE_REMOTE));
			wire        above      = $signed(fn_val[f]) > $signed(fn_hi[f]);
			wire        below      = $signed(fn_val[f]) < $signed(fn_lo[f]);
			wire [2:0]  next_hi_cnt = !above ? 3'h0 : (hi_cnt >= fq_depth) ? hi_cnt : hi_cnt + 3'h1;
			wire [2:0]  next_lo_cnt = !below ? 3'h0 : (lo_cnt >= fq_depth) ? lo_cnt : lo_cnt + 3'h1;

			assign hi_valid[f] = upd & (next_hi_cnt >= fq_depth);
			assign lo_valid[f] = upd & (next_lo_cnt >= fq_depth);

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					hi_cnt <= 3'h0;
					lo_cnt <= 3'h0;
				end else if (upd) begin
					hi_cnt <= next_hi_cnt;
					lo_cnt <= next_lo_cnt;
				end
			end
		end

		for (f = 0; f < 2; f++) begin : g_zone
			logic armed_hi;
			logic flag;
			assign set_int[f] = armed_hi ? lo_valid[f] : hi_valid[f];
			// one process per flag keeps a single driver per variable
			assign stat[f]    = flag;

			// flags move only on a measurement or a clear
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					flag     <= 1'b0;
					armed_hi <= 1'b0;
				end else if (!mode_int) begin
					if (hi_valid[f]) begin
						flag     <= 1'b1;
						armed_hi <= 1'b1;
					end else if (lo_valid[f]) begin
						flag     <= 1'b0;
						armed_hi <= 1'b0;
					end
				// set wins over read or halt clear
				end else if (set_int[f]) begin
					flag     <= 1'b1;
					armed_hi <= ~armed_hi;
				end else if (clear_int) begin
					flag <= 1'b0;
					if (halt_rise) armed_hi <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			overheat_out_state <= 1'b0;
		end else if (hi_valid[2]) begin
			overheat_out_state <= 1'b1;
		end else if (lo_valid[2]) begin
			overheat_out_state <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alert_pin    <= '0;
			overheat_out <= '0;
		end else begin
			alert_pin.o     <= 1'b0;
			alert_pin.oe    <= (|stat) & ~cfg_mask;
			overheat_out.o  <= 1'b0;
			overheat_out.oe <= overheat_out_state;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_sda_low_only: assert property (@(posedge clk) disable iff (sys_rst)
		sda_oe |-> (sda_o == 1'b0) && (state inside {ST_ADDR_ACK, ST_CMD_ACK, ST_WDATA_ACK, ST_RDATA}))
		else $error("data line driven outside ack or read data");

	a_foreign_addr: assert property (@(posedge clk) disable iff (sys_rst)
		(state == ST_ADDR && byte_end && !addr_hit) |=> (state == ST_IDLE) && !sda_oe && !selected)
		else $error("device answered a foreign address");

	a_cmd_latch: assert property (@(posedge clk) disable iff (sys_rst)
		cmd_wr |=> (ptr == $past(shift)))
		else $error("command byte not latched into pointer");

	a_pointer_holds: assert property (@(posedge clk) disable iff (sys_rst)
		!cmd_wr |=> $stable(ptr))
		else $error("pointer changed without a command byte");

	a_mask_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		(cfg_mask && $past(cfg_mask)) |-> !alert_pin.oe)
		else $error("alert driven while masked");

	a_read_clears: assert property (@(posedge clk) disable iff (sys_rst)
		(mode_int && rd_load && set_int == 2'b00) |=> (stat == 2'b00))
		else $error("read did not clear status in interrupt mode");

	a_comp_release: assert property (@(posedge clk) disable iff (sys_rst)
		(!mode_int && $past(!mode_int) && $fell(stat[0])) |-> $past(lo_valid[0]))
		else $error("comparator status fell without filtered low event");

	a_overheat_out_follow: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |-> (overheat_out.oe == $past(overheat_out_state)))
		else $error("overheat pin does not follow its state");

	a_fault_full: assert property (@(posedge adc_clk) disable iff (adc_rst)
		(conv_done && adc_zone == ZONE_REMOTE && fault_sync[1] && !busy_sync[1] && !halt_sync[1])
		|=> (res.value == FULL_SCALE) && (res.zone == ZONE_REMOTE))
		else $error("faulty remote diode not forced to full scale");

	a_abort_restart: assert property (@(posedge adc_clk) disable iff (adc_rst)
		busy_sync[1] |=> (adc_zone == ZONE_REMOTE) && (conv_cnt == 16'h0000) && $stable(res_tgl))
		else $error("conversion not aborted by bus access");

endmodule
`default_nettype wire

/* File: verification/tzs_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// two-wire host: owns the bus clock, pulls data low or lets the pull-up win
module tzs_host_model (
	// system
	input  wire logic clk,
	// bus
	output var  logic scl,
	output var  logic sda_pull,
	input  wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic cmd_ok(input logic [7:0] c);
		return c inside {tzs_pkg::REG_LOCAL_TEMP, tzs_pkg::REG_CONTROL, tzs_pkg::REG_LOCAL_HYST,
			tzs_pkg::REG_LOCAL_SET, tzs_pkg::REG_REMOTE_TEMP, tzs_pkg::REG_REMOTE_HYST,
			tzs_pkg::REG_REMOTE_SET, tzs_pkg::REG_RELEASE, tzs_pkg::REG_TRIP};
	endfunction
	task automatic bus_bit(input logic b, output logic r);
		sda_pull <= !b;
		wait_clk(32);
		scl <= 1'b1;
		wait_clk(62);
		r = sda;
		scl <= 1'b0;
		wait_clk(32);
	endtask
	task automatic bus_start();
		sda_pull <= 1'b0;
		wait_clk(32);
		scl <= 1'b1;
		wait_clk(62);
		sda_pull <= 1'b1;
		wait_clk(62);
		scl <= 1'b0;
		wait_clk(32);
	endtask
	task automatic bus_stop();
		sda_pull <= 1'b1;
		wait_clk(32);
		scl <= 1'b1;
		wait_clk(62);
		sda_pull <= 1'b0;
		wait_clk(62);
	endtask
	task automatic send_byte(input logic [7:0] v, inout logic ok);
		logic r;
		for (int i = 7; i >= 0; i--) bus_bit(v[i], r);
		bus_bit(1'b1, r);
		ok = ok & !r;
	endtask
	task automatic get_byte(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bus_bit(1'b1, r);
			v[i] = r;
		end
		// nack ends the read
		bus_bit(1'b1, r);
	endtask
	task automatic probe(input logic [6:0] a, output logic ok);
		ok = 1'b1;
		bus_start();
		send_byte({a, 1'b0}, ok);
		bus_stop();
	endtask
	task automatic write_reg(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] v, output logic ok);
		// reserved commands are refused, never sent
		ok = cmd_ok(cmd);
		if (ok) begin
			bus_start();
			send_byte({a, 1'b0}, ok);
			send_byte(cmd, ok);
			send_byte(v, ok);
			bus_stop();
		end
	endtask
	task automatic read_tail(input logic [6:0] a, output logic [7:0] v, inout logic ok);
		bus_start();
		send_byte({a, 1'b1}, ok);
		get_byte(v);
		bus_stop();
	endtask
	task automatic read_reg(input logic [6:0] a, input logic [7:0] cmd, output logic [7:0] v, output logic ok);
		// reserved commands are refused, never sent
		ok = cmd_ok(cmd);
		v  = 8'h00;
		if (ok) begin
			bus_start();
			send_byte({a, 1'b0}, ok);
			send_byte(cmd, ok);
			read_tail(a, v, ok);
		end
	endtask
	task automatic recv_byte(input logic [6:0] a, output logic [7:0] v, output logic ok);
		ok = 1'b1;
		read_tail(a, v, ok);
	endtask
endmodule
`default_nettype wire

/* File: verification/two_zone_thermal_supervisor_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module two_zone_thermal_supervisor_bench;
	import tzs_pkg::*;
	// ----------------------------------------
	// clocks, wires, instances
	// ----------------------------------------
	logic       clk        = 1'b0;
	logic       adc_clk    = 1'b0;
	logic       sys_rst    = 1'b1;
	logic [7:0] adc_sample = 8'hE7;
	logic       sense_bad  = 1'b0;
	logic       a0         = 1'b0;
	logic       scl;
	logic       host_pull;
	logic       sda_o;
	logic       sda_oe;
	wire logic  sda_w;
	tzs_od_t    alert_pin;
	tzs_od_t    overheat_out;
	int         fail_count  = 0;
	int         comparisons = 0;
	int         cycles      = 0;
	logic       ok;
	logic [7:0] d;
	always #10 clk = ~clk;
	// odd offset keeps the conversion clock out of phase
	initial begin
		#7;
		forever #24 adc_clk = ~adc_clk;
	end
	// pull-up: any party pulling wins
	assign sda_w = !(host_pull || sda_oe);
	tzs_core #(.LOCAL_CONV_CYC(16'h0004)) i_tzs_core (
		.clk(clk), .sys_rst(sys_rst), .adc_clk(adc_clk), .adc_sample(adc_sample),
		.remote_diode_sense_bad(sense_bad), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_select_pin(a0), .alert_pin(alert_pin), .overheat_out(overheat_out));
	tzs_host_model i_tzs_host_model (.clk(clk), .scl(scl), .sda_pull(host_pull), .sda(sda_w));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
		comparisons++;
		if (got !== exp) begin
			$display("MISMATCH %0t %s got %h want %h", $time, msg, got, exp);
			fail_count++;
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
	endtask
	function automatic logic [6:0] dev();
		return {ADDR_UPPER, a0};
	endfunction
	task automatic pins(input logic a, input logic o, input string msg);
		check({5'h00, alert_pin.o, overheat_out.o, alert_pin.oe, overheat_out.oe}, {7'h00, a, o}, msg);
	endtask
	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp, input string msg);
		i_tzs_host_model.read_reg(dev(), cmd, d, ok);
		check({ok, d}, {1'b1, exp}, msg);
	endtask
	task automatic rv(input logic [7:0] exp, input string msg);
		i_tzs_host_model.recv_byte(dev(), d, ok);
		check({ok, d}, {1'b1, exp}, msg);
	endtask
	task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
		i_tzs_host_model.write_reg(dev(), cmd, v, ok);
		check({8'h00, ok}, 9'h001, "write not acked");
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 99000) begin
			check(9'h001, 9'h000, "timeout");
			finish_test();
		end
	end
	always @(negedge clk) begin
		if (sda_oe === 1'b1) check({8'h00, sda_o}, 9'h000, "data driven high");
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic s_reset();
		rd(REG_CONTROL, 8'h00, "control default");
		rd(REG_LOCAL_SET, RST_LOCAL_SET, "local set default");
		rd(REG_REMOTE_TEMP, 8'hE7, "negative remote");
	endtask
	task automatic s_address();
		i_tzs_host_model.probe({ADDR_UPPER, !a0}, ok);
		check({8'h00, ok}, 9'h000, "foreign address acked");
		a0 <= 1'b1;
		wait_clk(10);
		rv(8'hE7, "pin address");
		a0 <= 1'b0;
		wait_clk(10);
	endtask
	task automatic s_write();
		wr(REG_REMOTE_SET, 8'h60);
		rd(REG_REMOTE_SET, 8'h60, "readback");
		rv(8'h60, "pointer kept");
		rd(REG_RELEASE, RST_RELEASE, "release default");
	endtask
	task automatic s_compare();
		adc_sample <= 8'h62;
		wait_clk(300);
		pins(1'b1, 1'b1, "hot pins");
		rd(REG_CONTROL, 8'hE0, "status flags");
		adc_sample <= 8'h10;
		wait_clk(300);
		pins(1'b0, 1'b0, "cold pins");
	endtask
	task automatic s_mask_fault();
		wr(REG_CONTROL, 8'h04);
		adc_sample <= 8'h62;
		wait_clk(300);
		pins(1'b0, 1'b1, "masked alert");
		adc_sample <= 8'h10;
		sense_bad <= 1'b1;
		wait_clk(300);
		pins(1'b0, 1'b1, "fault trips");
		rd(REG_REMOTE_TEMP, FULL_SCALE, "fault value");
		rv(FULL_SCALE, "fault persists");
		sense_bad <= 1'b0;
		wait_clk(300);
		pins(1'b0, 1'b0, "fault gone");
	endtask
	task automatic s_intr();
		wr(REG_CONTROL, 8'h02);
		adc_sample <= 8'h62;
		wait_clk(300);
		pins(1'b1, 1'b1, "intr set");
		i_tzs_host_model.recv_byte(dev(), d, ok);
		pins(1'b0, 1'b1, "read clears");
		wait_clk(300);
		pins(1'b0, 1'b1, "no repeat");
		adc_sample <= 8'h10;
		wait_clk(300);
		pins(1'b1, 1'b0, "under event");
		i_tzs_host_model.recv_byte(dev(), d, ok);
		pins(1'b0, 1'b0, "read clears again");
		adc_sample <= 8'h62;
		wait_clk(300);
		pins(1'b1, 1'b1, "intr set again");
		wr(REG_CONTROL, 8'h03);
		pins(1'b0, 1'b1, "halt clears");
	endtask
	task automatic s_filter();
		for (int c = 0; c < 4; c++) begin
			adc_sample <= 8'h10;
			wr(REG_CONTROL, {3'b000, c[1:0], 3'b000});
			wait_clk(400);
			adc_sample <= 8'h62;
			wait_clk(60);
			if (c != 1) pins(c == 0, c == 0, "filter early");
			wait_clk(400);
			pins(1'b1, 1'b1, "filter late");
		end
	endtask
	initial begin
		wait_clk(16);
		sys_rst <= 1'b0;
		wait_clk(8);
		s_reset();
		s_address();
		s_write();
		s_compare();
		s_mask_fault();
		s_intr();
		s_filter();
		finish_test();
	end
endmodule
`default_nettype wire
